// file: src/fcdp_params.svh
/*
 Timing counts, field positions and mode codes for the fast comm controller
 data-pin layer. Included by the package, the cell transmitter and the top module.
*/
`ifndef FCDP_PARAMS_SVH
`define FCDP_PARAMS_SVH
`define FCDP_CELL_OCTETS   53
`define FCDP_CNT_W         6
`define FCDP_IDLE_OCTET    8'h00
`define FCDP_HDR_IDLE_LAST 8'h01
`define FCDP_HDR_OCTETS    4
`define FCDP_MODE_GPIO     3'h0
`define FCDP_MODE_CELL     3'h1
`define FCDP_MODE_NIBBLE   3'h2
`define FCDP_MODE_SERIAL   3'h3
`define FCDP_MODE_DMANUM   3'h4
`define FCDP_DIR_TX        1'b0
`define FCDP_DIR_RX        1'b1
`define FCDP_NIB_BIT0      0
`define FCDP_SER_BIT       0
`endif

// file: src/fcdp_pkg.sv
/*
 Types for the fast comm controller data-pin layer.
 Assumes the parameter header is on the include path.
*/
`include "fcdp_params.svh"
package fcdp_pkg;
   typedef enum logic [2:0]
   {
      FCDP_GPIO   = `FCDP_MODE_GPIO,
      FCDP_CELL   = `FCDP_MODE_CELL,
      FCDP_NIBBLE = `FCDP_MODE_NIBBLE,
      FCDP_SERIAL = `FCDP_MODE_SERIAL,
      FCDP_DMANUM = `FCDP_MODE_DMANUM
   } fcdp_mode_t;

   typedef struct packed
   {
      logic       valid;
      logic [4:0] module_code;
      logic       direction;
   } fcdp_dma_t;

   typedef struct packed
   {
      logic [6:0] out;
      logic [6:0] oe_n;
   } fcdp_pins_t;
endpackage : fcdp_pkg

// file: src/fcdp_sync.sv
/*
 Two flip-flop synchroniser for pin inputs.
 Assumes the input is asynchronous to clk_i; only the second stage is used.
*/
`timescale 1ns/10ps
module fcdp_sync
   import fcdp_pkg::*;
#(
   parameter int W = 7
)
(
   input  wire logic         clk_i,  // System clock
   input  wire logic         rst_i,  // Synchronous reset
   input  wire logic [W-1:0] d_i,    // Asynchronous input
   output logic      [W-1:0] q_o     // Synchronised output
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s1_d;
   logic [W-1:0] s2_q;
   logic [W-1:0] s2_d;

   always_comb
   begin
      s1_d = d_i;
      s2_d = s1_q;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   assign q_o = s2_q;
endmodule : fcdp_sync

// file: src/fcdp_cell_tx.sv
/*
 Cell transmitter: emits 53-octet cells, filling with idle cells when the
 user has no payload cell ready. Assumes the user offers whole cells.
*/
`timescale 1ns/10ps
`include "fcdp_params.svh"
module fcdp_cell_tx
   import fcdp_pkg::*;
(
   input  wire logic       clk_i,    // System clock
   input  wire logic       rst_i,    // Synchronous reset
   input  wire logic       en_i,     // Cell mode active
   input  wire logic       valid_i,  // User octet valid
   input  wire logic [7:0] data_i,   // User octet
   output logic            ready_o,  // User octet taken
   output logic [7:0]      octet_o,  // Octet on bus
   output logic            sof_o,    // First octet of cell
   output logic            idle_o    // Current cell is idle
);
   logic [`FCDP_CNT_W-1:0] cnt_q, cnt_d;
   logic                   idle_q, idle_d;
   logic [7:0]             oct_q, oct_d;
   logic                   sof_q, sof_d;
   logic                   start;
   logic                   cur_idle;

   always_comb
   begin
      start    = (cnt_q == '0);
      cur_idle = start ? !valid_i : idle_q;
      cnt_d    = cnt_q;
      idle_d   = idle_q;
      oct_d    = oct_q;
      sof_d    = 1'b0;
      ready_o  = 1'b0;
      if (en_i)
      begin
         idle_d = cur_idle;
         sof_d  = start;
         if (cnt_q == 6'(`FCDP_CELL_OCTETS - 1))
            cnt_d = '0;
         else
            cnt_d = cnt_q + 6'h01;
         if (cur_idle)
            oct_d = (cnt_q == 6'(`FCDP_HDR_OCTETS - 1)) ? `FCDP_HDR_IDLE_LAST
                                                       : `FCDP_IDLE_OCTET;
         else
         begin
            oct_d   = data_i;
            ready_o = 1'b1;
         end
      end
      else
         cnt_d = '0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_q  <= '0;
         idle_q <= 1'b1;
         oct_q  <= '0;
         sof_q  <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         idle_q <= idle_d;
         oct_q  <= oct_d;
         sof_q  <= sof_d;
      end
   end

   assign octet_o = oct_q;
   assign sof_o   = sof_q;
   assign idle_o  = idle_q;
endmodule : fcdp_cell_tx

// file: src/fcdp_top.sv
/*
 Data-pin layer of the first fast comm controller on port A pins 18..12.
 Muxes cell, nibble, serial and DMA module-number functions onto shared pins.
 Assumes the pins are resolved by the bench from out/oe_n; one clock.
*/
`timescale 1ns/10ps
`include "fcdp_params.svh"
module fcdp_top
   import fcdp_pkg::*;
(
   input  wire logic       clk_i,          // 10 MHz system clock
   input  wire logic       rst_i,          // Synchronous reset, high
   input  wire fcdp_mode_t mode_i,         // Selected pin function
   input  wire logic [6:0] gpio_out_i,     // GPIO output values, pins 18..12
   input  wire logic [6:0] gpio_dir_i,     // GPIO direction, 1 = output
   output logic      [6:0] gpio_in_o,      // GPIO sampled inputs
   input  wire logic       cell_valid_i,   // User transmit octet valid
   input  wire logic [7:0] cell_data_i,    // User transmit octet
   output logic            cell_ready_o,   // User transmit octet taken
   output logic [7:0]      cell_tx_o,      // Transmit cell bus
   output logic            cell_tx_sof_o,  // Transmit first octet
   output logic            cell_tx_idle_o, // Transmit cell is idle fill
   input  wire logic       rx_enb_i,       // Receive enable, from controller
   input  wire logic       rx_clav_i,      // PHY cell available (pin)
   input  wire logic [7:0] cell_rx_i,      // Receive cell bus (pins)
   output logic            rx_enb_n_o,     // Receive enable to PHY, low active
   output logic [7:0]      cell_rx_o,      // Received octet
   output logic            cell_rx_vld_o,  // Received octet valid
   output logic            cell_rx_sof_o,  // Received first octet of cell
   input  wire logic [3:0] nib_tx_i,       // Nibble to transmit
   output logic [3:0]      nib_tx_o,       // Transmit nibble bus
   input  wire logic [3:0] nib_rx_i,       // Receive nibble bus (pins)
   output logic [3:0]      nib_rx_o,       // Received nibble
   input  wire logic       ser_tx_i,       // Serial bit to transmit
   output logic            ser_rx_o,       // Received serial bit
   input  wire fcdp_dma_t  dma_i,          // Serial DMA transfer descriptor
   input  wire logic [6:0] pin_in_i,       // Port pins 18..12 input level
   output fcdp_pins_t      pins_o          // Port pins 18..12 drive, oe low
);
   logic [6:0]             pin_s;
   logic [7:0]             crx_s;
   logic [3:0]             nrx_s;
   logic                   clav_s;
   logic [7:0]             txoct;
   logic                   txsof;
   logic                   txidle;
   logic [`FCDP_CNT_W-1:0] rcnt_q, rcnt_d;
   logic [7:0]             rdat_q, rdat_d;
   logic                   rvld_q, rvld_d;
   logic                   rsof_q, rsof_d;
   logic                   renb_q, renb_d;
   logic                   rfst_q, rfst_d;
   logic                   cap1_q, cap1_d;
   logic                   fst1_q, fst1_d;
   logic                   cap2_q, cap2_d;
   logic                   fst2_q, fst2_d;
   logic [3:0]             ntx_q, ntx_d;
   logic [3:0]             nrx_q, nrx_d;
   logic                   stx_q, stx_d;
   logic                   srx_q, srx_d;
   logic [5:0]             mnum_q, mnum_d;
   fcdp_pins_t             pins_q, pins_d;
   logic [6:0]             gin_q, gin_d;

   // Port pins and cell/nibble receive buses all come from outside
   fcdp_sync #(.W(7)) u_sync_pin
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pin_in_i),
      .q_o   (pin_s)
   );

   fcdp_sync #(.W(13)) u_sync_rx
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({rx_clav_i, cell_rx_i, nib_rx_i}),
      .q_o   ({clav_s, crx_s, nrx_s})
   );

   fcdp_cell_tx u_cell_tx
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (mode_i == FCDP_CELL),
      .valid_i (cell_valid_i),
      .data_i  (cell_data_i),
      .ready_o (cell_ready_o),
      .octet_o (txoct),
      .sof_o   (txsof),
      .idle_o  (txidle)
   );

   // Receive framing: octets are counted as enables are issued, so a cell
   // ends after exactly 53 enables and the next cell needs a fresh clav.
   always_comb
   begin
      rcnt_d = rcnt_q;
      renb_d = 1'b0;
      rfst_d = 1'b0;
      if (mode_i == FCDP_CELL)
      begin
         // Start a cell only once the PHY reports a complete one
         renb_d = rx_enb_i && (rcnt_q != '0 || clav_s);
         rfst_d = renb_d && (rcnt_q == '0);
         if (renb_d)
         begin
            if (rcnt_q == 6'(`FCDP_CELL_OCTETS - 1))
               rcnt_d = '0;
            else
               rcnt_d = rcnt_q + 6'h01;
         end
      end
      else
         rcnt_d = '0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rcnt_q <= '0;
         renb_q <= 1'b0;
         rfst_q <= 1'b0;
      end
      else
      begin
         rcnt_q <= rcnt_d;
         renb_q <= renb_d;
         rfst_q <= rfst_d;
      end
   end

   // Octets driven during an enable cycle reach crx_s two edges later, through
   // the synchroniser, so the capture strobe is delayed by the same two edges.
   // Sampling on renb_q directly would take the released bus instead of data.
   always_comb
   begin
      cap1_d = renb_q;
      fst1_d = rfst_q;
      cap2_d = cap1_q;
      fst2_d = fst1_q;
      rdat_d = rdat_q;
      rvld_d = 1'b0;
      rsof_d = 1'b0;
      if (cap2_q)
      begin
         rdat_d = crx_s;
         rvld_d = 1'b1;
         rsof_d = fst2_q;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cap1_q <= 1'b0;
         fst1_q <= 1'b0;
         cap2_q <= 1'b0;
         fst2_q <= 1'b0;
         rdat_q <= '0;
         rvld_q <= 1'b0;
         rsof_q <= 1'b0;
      end
      else
      begin
         cap1_q <= cap1_d;
         fst1_q <= fst1_d;
         cap2_q <= cap2_d;
         fst2_q <= fst2_d;
         rdat_q <= rdat_d;
         rvld_q <= rvld_d;
         rsof_q <= rsof_d;
      end
   end

   // Pin mux: one function per pin at a time. Pin index 6 is pin 18.
   always_comb
   begin
      ntx_d  = ntx_q;
      nrx_d  = nrx_q;
      stx_d  = stx_q;
      srx_d  = srx_q;
      mnum_d = mnum_q;
      gin_d  = gin_q;
      pins_d.out  = '0;
      pins_d.oe_n = '1;
      unique case (mode_i)
         FCDP_GPIO:
         begin
            pins_d.out  = gpio_out_i;
            pins_d.oe_n = ~gpio_dir_i;
            gin_d       = pin_s;
         end
         FCDP_CELL:
         begin
            // Only pin 18 carries transmit bit 7 here; rest of octet on bus
            pins_d.out[6]  = txoct[7];
            pins_d.oe_n[6] = 1'b0;
         end
         FCDP_NIBBLE:
         begin
            ntx_d          = nib_tx_i;
            nrx_d          = nrx_s;
            pins_d.out[6]  = nib_tx_i[`FCDP_NIB_BIT0];
            pins_d.oe_n[6] = 1'b0;
         end
         FCDP_SERIAL:
         begin
            stx_d          = ser_tx_i;
            srx_d          = pin_s[5];
            pins_d.out[6]  = ser_tx_i;
            pins_d.oe_n[6] = 1'b0;
         end
         FCDP_DMANUM:
         begin
            // Pins 13,12 carry code bits 2,3
            mnum_d = dma_i.valid ? {dma_i.direction, dma_i.module_code}
                                 : 6'h00;
            pins_d.out[1:0]  = {mnum_d[2], mnum_d[3]};
            pins_d.oe_n[1:0] = 2'b00;
         end
         default:
         begin
            // Unused mode codes leave every pin released
            pins_d.oe_n = '1;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ntx_q  <= '0;
         nrx_q  <= '0;
         stx_q  <= 1'b0;
         srx_q  <= 1'b0;
         mnum_q <= '0;
         gin_q  <= '0;
         pins_q <= '{out: 7'h00, oe_n: 7'h7f};
      end
      else
      begin
         ntx_q  <= ntx_d;
         nrx_q  <= nrx_d;
         stx_q  <= stx_d;
         srx_q  <= srx_d;
         mnum_q <= mnum_d;
         gin_q  <= gin_d;
         pins_q <= pins_d;
      end
   end

   assign cell_tx_o      = txoct;
   assign cell_tx_sof_o  = txsof;
   assign cell_tx_idle_o = txidle;
   assign rx_enb_n_o     = ~renb_q;
   assign cell_rx_o      = rdat_q;
   assign cell_rx_vld_o  = rvld_q;
   assign cell_rx_sof_o  = rsof_q;
   assign nib_tx_o       = ntx_q;
   assign nib_rx_o       = nrx_q;
   assign ser_rx_o       = srx_q;
   assign gpio_in_o      = gin_q;
   assign pins_o         = pins_q;
endmodule : fcdp_top

// file: tb/fcdp_top_properties.sv
/*
 Concurrent checks on the data-pin layer top ports.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module fcdp_top_properties
   import fcdp_pkg::*;
(
   input  wire logic       clk_i,          // Clock
   input  wire logic       rst_i,          // Reset
   input  wire fcdp_mode_t mode_i,         // Pin function
   input  wire logic       cell_ready_o,   // Octet taken
   input  wire logic [7:0] cell_tx_o,      // Transmit octet
   input  wire logic       cell_tx_sof_o,  // Cell start
   input  wire logic       cell_tx_idle_o, // Idle cell
   input  wire logic       rx_enb_i,       // Receive request
   input  wire logic       rx_enb_n_o,     // Receive enable
   input  wire logic       cell_rx_vld_o,  // Receive octet valid
   input  wire logic [3:0] nib_tx_i,       // Nibble in
   input  wire logic [3:0] nib_tx_o,       // Nibble out
   input  wire logic       ser_tx_i,       // Serial bit in
   input  wire fcdp_dma_t  dma_i,          // DMA descriptor
   input  wire fcdp_pins_t pins_o          // Pin drive
);
   logic [6:0] gap_q, gap_d;
   logic       seen_q, seen_d;

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Gap is only trusted once a cell start was seen without leaving cell mode
   always_comb
   begin
      gap_d  = cell_tx_sof_o ? 7'h01 : gap_q + 7'h01;
      seen_d = (seen_q | cell_tx_sof_o) & (mode_i == FCDP_CELL);
   end
   always_ff @(posedge clk_i)
   begin
      gap_q  <= rst_i ? 7'h00 : gap_d;
      seen_q <= rst_i ? 1'b0 : seen_d;
   end

   property p_ready_mode;
      cell_ready_o |-> mode_i == FCDP_CELL;
   endproperty
   a_ready_mode: assert property (p_ready_mode) else $error("ready out of cell mode");

   property p_cell_len;
      cell_tx_sof_o && seen_q |-> gap_q == 7'h35;
   endproperty
   a_cell_len: assert property (p_cell_len) else $error("cell length wrong");

   property p_idle_hdr;
      cell_tx_sof_o && cell_tx_idle_o ##3 mode_i == FCDP_CELL |-> cell_tx_o == 8'h01;
   endproperty
   a_idle_hdr: assert property (p_idle_hdr) else $error("idle header wrong");

   property p_rx_enb;
      !rx_enb_n_o |-> $past(rx_enb_i);
   endproperty
   a_rx_enb: assert property (p_rx_enb) else $error("enable without request");

   property p_rx_vld;
      cell_rx_vld_o |-> $past(rx_enb_n_o, 3) == 1'b0;
   endproperty
   a_rx_vld: assert property (p_rx_vld) else $error("octet without enable");

   property p_nib_tx;
      $past(mode_i == FCDP_NIBBLE && !rst_i) |-> nib_tx_o == $past(nib_tx_i);
   endproperty
   a_nib_tx: assert property (p_nib_tx) else $error("nibble out wrong");

   property p_ser_tx;
      $past(mode_i == FCDP_SERIAL && !rst_i) |-> !pins_o.oe_n[6] && pins_o.out[6] == $past(ser_tx_i);
   endproperty
   a_ser_tx: assert property (p_ser_tx) else $error("serial pin wrong");

   property p_dma_code;
      $past(mode_i == FCDP_DMANUM && !rst_i) |-> pins_o.out[1:0] == ($past(dma_i.valid) ?
         {$past(dma_i.module_code[2]), $past(dma_i.module_code[3])} : 2'h0);
   endproperty
   a_dma_code: assert property (p_dma_code) else $error("module code pins wrong");
endmodule : fcdp_top_properties

bind fcdp_top fcdp_top_properties fcdp_top_properties_inst (.*);

// file: tb/fcdp_phy_model.sv
/*
 Behavioural receive PHY: offers one cell for each load pulse.
 Assumes the enable input is the device's low-active receive enable.
*/
`timescale 1ns/10ps
module fcdp_phy_model
   import fcdp_pkg::*;
(
   input  wire logic       clk_i,   // Clock
   input  wire logic       rst_i,   // Reset
   input  wire logic       load_i,  // A full cell is ready
   input  wire logic       enb_n_i, // Receive enable, low
   output logic            clav_o,  // Cell available
   output logic [7:0]      data_o   // Receive data pins
);
   logic [7:0] cnt_q, cnt_d;
   logic       clav_q, clav_d;

   always_comb
   begin
      clav_d = load_i | (clav_q & enb_n_i);
      cnt_d  = load_i ? 8'h00 : cnt_q + {7'h00, ~enb_n_i};
   end
   always_ff @(posedge clk_i)
   begin
      clav_q <= rst_i ? 1'b0 : clav_d;
      cnt_q  <= rst_i ? 8'h00 : cnt_d;
   end
   assign clav_o = clav_q;
   // Released bus shows the inverse so a stale octet never passes for data
   assign data_o = enb_n_i ? ~cnt_q : cnt_q;
endmodule : fcdp_phy_model

// file: tb/testbench.sv
/*
 Self-checking bench for the data-pin layer, one task per scenario.
 Assumes a 10 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module testbench
   import fcdp_pkg::*;
;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   fcdp_mode_t mode_i = FCDP_GPIO;
   logic [6:0] gpio_out_i = 7'h00, gpio_dir_i = 7'h00, pin_q = 7'h00, gpio_in_o, pin_in_i;
   logic       cell_valid_i = 1'b0, rx_enb_i = 1'b0, ser_tx_i = 1'b0, phy_load = 1'b0;
   logic [7:0] cell_data_i = 8'h00, cell_tx_o, cell_rx_i, cell_rx_o;
   logic [3:0] nib_tx_i = 4'h0, nib_rx_i = 4'h0, nib_tx_o, nib_rx_o;
   logic       cell_ready_o, cell_tx_sof_o, cell_tx_idle_o, rx_clav_i, rx_enb_n_o;
   logic       cell_rx_vld_o, cell_rx_sof_o, ser_rx_o;
   fcdp_dma_t  dma_i = 7'h00;
   fcdp_pins_t pins_o;
   int         n_errors = 0, samples_checked = 0;

   // Pin level: design drive where enabled, else the far side
   assign pin_in_i = (~pins_o.oe_n & pins_o.out) | (pins_o.oe_n &
      ((mode_i == FCDP_CELL) ? {1'b1, cell_rx_i[7:2]} : pin_q));

   always #50 clk_i = ~clk_i;

   fcdp_top fcdp_top_inst (.*);
   fcdp_phy_model fcdp_phy_model_inst (.clk_i(clk_i), .rst_i(rst_i), .load_i(phy_load),
      .enb_n_i(rx_enb_n_o), .clav_o(rx_clav_i), .data_o(cell_rx_i));

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic settle;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
   endtask : settle

   task automatic t_gpio;
      @(posedge clk_i);
      gpio_dir_i <= 7'h55;
      gpio_out_i <= 7'h33;
      pin_q <= 7'h2a;
      settle();
      chk(pins_o.oe_n, 7'h2a);
      chk(pins_o.out & 7'h55, 7'h11);
      chk(gpio_in_o, 7'h3b);
      $display("test gpio done");
   endtask : t_gpio

   task automatic t_cell_tx;
      int k, i, c;
      k = 0;
      i = -1;
      c = 0;
      @(posedge clk_i);
      mode_i <= FCDP_CELL;
      cell_valid_i <= 1'b1;
      repeat (120)
      begin
         @(negedge clk_i);
         if (i == 53)
            chk(cell_tx_sof_o, 1'b1);
         if (cell_tx_sof_o === 1'b1)
         begin
            i = 0;
            c++;
         end
         if (i >= 0 && i < 53)
         begin
            chk(cell_tx_o, (c == 1) ? {i[0], i[6:0]} : {7'h00, i == 3});
            if (c == 1 && i > 0)
               chk(pins_o.out[6], !i[0]);
            chk(cell_tx_idle_o, c != 1);
            i++;
         end
         if (cell_ready_o === 1'b1)
            k++;
         @(posedge clk_i);
         cell_data_i <= {k[0], k[6:0]};
         if (k >= 53)
            cell_valid_i <= 1'b0;
      end
      chk(pins_o.oe_n, 7'h3f);
      if (c < 2)
      begin
         n_errors++;
         report_and_stop();
      end
      $display("test cell transmit done");
   endtask : t_cell_tx

   task automatic t_cell_rx;
      int n, s;
      n = 0;
      s = 0;
      @(posedge clk_i);
      phy_load <= 1'b1;
      rx_enb_i <= 1'b1;
      @(posedge clk_i);
      phy_load <= 1'b0;
      repeat (100)
      begin
         @(negedge clk_i);
         if (cell_rx_vld_o === 1'b1)
         begin
            chk(cell_rx_o, n[7:0]);
            n++;
         end
         if (cell_rx_sof_o === 1'b1)
         begin
            chk(n[7:0], 8'h01);
            s++;
         end
      end
      chk(n[7:0], 8'h35);
      chk(s[7:0], 8'h01);
      chk(rx_enb_n_o, 1'b1);
      if (n == 0)
      begin
         n_errors++;
         report_and_stop();
      end
      @(posedge clk_i);
      rx_enb_i <= 1'b0;
      $display("test cell receive done");
   endtask : t_cell_rx

   task automatic t_nib;
      logic [3:0] v;
      for (int j = 0; j < 4; j++)
      begin
         v = 4'h1 << j;
         @(posedge clk_i);
         mode_i <= FCDP_NIBBLE;
         nib_tx_i <= v;
         nib_rx_i <= v;
         pin_q <= {1'b0, v[0], v[1], v[2], v[3], 2'b00};
         settle();
         chk(nib_tx_o, v);
         chk(pins_o.out[6], v[0]);
         chk(nib_rx_o, v);
      end
      $display("test nibble done");
   endtask : t_nib

   task automatic t_ser;
      for (int j = 0; j < 2; j++)
      begin
         @(posedge clk_i);
         mode_i <= FCDP_SERIAL;
         ser_tx_i <= (j == 0);
         pin_q <= {1'b0, j == 0, 5'h00};
         settle();
         chk(pins_o.out[6], j == 0);
         chk(pins_o.oe_n[6], 1'b0);
         chk(ser_rx_o, j == 0);
      end
      $display("test serial done");
   endtask : t_ser

   task automatic t_dma;
      logic [4:0] code;
      for (int j = 0; j < 5; j++)
      begin
         code = {1'b0, j[1:0], 2'b01};
         @(posedge clk_i);
         mode_i <= FCDP_DMANUM;
         dma_i <= {j < 4, code, j[0]};
         settle();
         chk(pins_o.out[1:0], (j < 4) ? {code[2], code[3]} : 2'h0);
         if (j < 4)
            chk(pins_o.oe_n[1:0], 2'h0);
      end
      $display("test module number done");
   endtask : t_dma

   initial
   begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk(pins_o.oe_n, 7'h7f);
      chk({rx_enb_n_o, cell_tx_idle_o}, 2'h3);
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_gpio();
      t_cell_tx();
      t_cell_rx();
      t_nib();
      t_ser();
      t_dma();
      report_and_stop();
   end
endmodule : testbench
